// [core/lfsh_map.svh]
// Register offsets, field positions, reset values of the fault handler
`ifndef LFSH_MAP_SVH
`define LFSH_MAP_SVH
`define LFSH_STN 64
`define LFSH_PTS 4
`define LFSH_IDX_LERR0 8'h04
`define LFSH_IDX_LERR3 8'h07
`define LFSH_IDX_RIOE0 8'h08
`define LFSH_IDX_RIOE3 8'h0B
`define LFSH_IDX_FLAGS 8'h1D
`define LFSH_IDX_CTRL 8'h30
`define LFSH_IDX_IRQ_ST 8'h31
`define LFSH_IDX_IRQ_MSK 8'h32
`define LFSH_FLG_SOME 0
`define LFSH_FLG_ALL 1
`define LFSH_FLG_RIO 2
`define LFSH_CTRL_STOP 0
`define LFSH_CTRL_LINK 1
`define LFSH_CTRL_RST 2'h2
`define LFSH_IRQ_HALT 3
`define LFSH_IRQ_W 4
`define LFSH_IRQ_RST 4'h0
`define LFSH_FLAGS_RST 16'h0000
`endif

// [core/lfsh_pkg.sv]
// Types shared by the fault handler modules
package lfsh_pkg;
`include "lfsh_map.svh"
  typedef logic [`LFSH_STN-1:0] lfsh_stn_t;
  typedef logic [`LFSH_STN*`LFSH_PTS-1:0] lfsh_img_t;
  typedef logic [15:0] lfsh_word_t;
  typedef logic [`LFSH_IRQ_W-1:0] lfsh_irq_t;
endpackage

// [core/lfsh_link_if.sv]
// Signals passed between the fault handler top and its helpers
`timescale 1ns/100ps
interface lfsh_link_if;
  import lfsh_pkg::*;
  logic halt;
  lfsh_stn_t link_err;
  lfsh_stn_t pwr_off;
  lfsh_stn_t rio_err;
  logic all_fail;
  lfsh_img_t in_raw;
  lfsh_img_t out_img;
  lfsh_img_t in_gated;
  lfsh_img_t out_gated;
  lfsh_word_t flags;
  modport top (
    output halt, link_err, pwr_off, rio_err, all_fail, in_raw, out_img,
    input in_gated, out_gated, flags
  );
  modport gate (
    input halt, link_err, pwr_off, in_raw, out_img,
    output in_gated, out_gated
  );
  modport flag (
    input link_err, rio_err, all_fail,
    output flags
  );
endinterface

// [core/lfsh_gate.sv]
// Per-station clearing of remote input images; output images cleared only on halt
`timescale 1ns/100ps
`include "lfsh_map.svh"
module lfsh_gate (
  lfsh_link_if.gate bus
);
  import lfsh_pkg::*;
  genvar s;
  generate
    for (s = 0; s < `LFSH_STN; s++) begin : g_stn
      // A failed or unpowered station reads as all points off
      assign bus.in_gated[s*`LFSH_PTS +: `LFSH_PTS] =
        (bus.link_err[s] || bus.pwr_off[s]) ? '0 :
        bus.in_raw[s*`LFSH_PTS +: `LFSH_PTS];
      // Outputs keep updating unless the controller itself halted
      assign bus.out_gated[s*`LFSH_PTS +: `LFSH_PTS] =
        bus.halt ? '0 :
        bus.out_img[s*`LFSH_PTS +: `LFSH_PTS];
    end
  endgenerate
endmodule

// [core/lfsh_flag.sv]
// Summary flags derived from the per-station error words and the all_fail input
`timescale 1ns/100ps
`include "lfsh_map.svh"
module lfsh_flag (
  lfsh_link_if.flag bus
);
  import lfsh_pkg::*;
  always_comb begin
    bus.flags = `LFSH_FLAGS_RST;
    bus.flags[`LFSH_FLG_SOME] = |bus.link_err;
    bus.flags[`LFSH_FLG_ALL] = bus.all_fail;
    bus.flags[`LFSH_FLG_RIO] = |bus.rio_err;
  end
endmodule

// [core/lfsh_top.sv]
// Fault handler of the field-network master: image gating and status
`timescale 1ns/100ps
`include "lfsh_map.svh"
// Operation
// - Controller halt: outputs off, link keeps running
// - Link-failed station: inputs off, outputs continue
// - Unpowered station: inputs off, outputs continue
// - Clear means off at once; continue means normal
// - Status word: one bit per error, 1 active
// - Bit 0: any link-error station bit set
// - Bit 1: link failed for all stations
// - Bit 2: any remote I/O error bit set
module lfsh_top (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Controller side
  input wire logic prog_err,
  input wire logic cpu_err,
  input wire lfsh_pkg::lfsh_img_t out_img,
  output lfsh_pkg::lfsh_img_t rem_in,
  // Link side
  input wire lfsh_pkg::lfsh_img_t in_raw,
  input wire lfsh_pkg::lfsh_stn_t link_err,
  input wire lfsh_pkg::lfsh_stn_t pwr_off,
  input wire lfsh_pkg::lfsh_stn_t rio_err,
  input wire logic all_fail,
  output lfsh_pkg::lfsh_img_t rem_out,
  output logic link_run,
  // Status
  output lfsh_pkg::lfsh_word_t err_flags,
  output logic irq
);
  import lfsh_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Internal state

  logic [1:0] ctrl_q;
  lfsh_irq_t irq_st_q;
  lfsh_irq_t irq_msk_q;
  lfsh_irq_t irq_ev;
  lfsh_word_t flags_q;
  lfsh_img_t rem_in_q;
  lfsh_img_t rem_out_q;
  logic link_run_q;
  logic irq_q;
  logic [31:0] prdata_q;
  logic [31:0] rd_d;
  logic pready_q;
  logic pslverr_q;
  logic hit_d;
  logic halt_w;
  logic halt_q;
  logic [7:0] idx;
  logic wr_acc;

  lfsh_link_if bus ();

  ////////////////////////////////////////////////////////////////////////
  // Helpers

  // Software stop acts like a program halt
  assign halt_w = prog_err || cpu_err || ctrl_q[`LFSH_CTRL_STOP];
  assign bus.halt = halt_w;
  assign bus.link_err = link_err;
  assign bus.pwr_off = pwr_off;
  assign bus.rio_err = rio_err;
  assign bus.all_fail = all_fail;
  assign bus.in_raw = in_raw;
  assign bus.out_img = out_img;

  lfsh_gate u_gate (
    .bus(bus.gate)
  );

  lfsh_flag u_flag (
    .bus(bus.flag)
  );

  ////////////////////////////////////////////////////////////////////////
  // Images and flags

  always_ff @(posedge clk) begin
    if (rst) begin
      rem_in_q <= '0;
      rem_out_q <= '0;
    end else begin
      rem_in_q <= bus.in_gated;
      rem_out_q <= bus.out_gated;
    end
  end

  // Reloaded every cycle so recovery needs no software action
  always_ff @(posedge clk) begin
    if (rst) begin
      flags_q <= `LFSH_FLAGS_RST;
    end else begin
      flags_q <= bus.flags;
    end
  end

  // The network keeps running through a controller halt
  always_ff @(posedge clk) begin
    if (rst) begin
      link_run_q <= 1'b0;
    end else begin
      link_run_q <= ctrl_q[`LFSH_CTRL_LINK];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      halt_q <= 1'b0;
    end else begin
      halt_q <= halt_w;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // APB slave

  assign idx = paddr[9:2];
  assign wr_acc = psel && penable && pready_q && pwrite && hit_d;

  always_comb begin
    rd_d = 32'h00000000;
    hit_d = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0);
    if (idx >= `LFSH_IDX_LERR0 && idx <= `LFSH_IDX_LERR3) begin
      rd_d[15:0] = link_err[(idx - `LFSH_IDX_LERR0) * 16 +: 16];
    end else if (idx >= `LFSH_IDX_RIOE0 && idx <= `LFSH_IDX_RIOE3) begin
      rd_d[15:0] = rio_err[(idx - `LFSH_IDX_RIOE0) * 16 +: 16];
    end else begin
      case (idx)
        `LFSH_IDX_FLAGS: rd_d[15:0] = flags_q;
        `LFSH_IDX_CTRL: rd_d[1:0] = ctrl_q;
        `LFSH_IDX_IRQ_ST: rd_d[`LFSH_IRQ_W-1:0] = irq_st_q;
        `LFSH_IDX_IRQ_MSK: rd_d[`LFSH_IRQ_W-1:0] = irq_msk_q;
        default: hit_d = 1'b0;
      endcase
    end
  end

  // One wait-free access phase; data prepared during setup
  always_ff @(posedge clk) begin
    if (rst) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end else begin
      pready_q <= psel && !penable;
      pslverr_q <= psel && !penable && !hit_d;
      if (psel && !penable) begin
        prdata_q <= (hit_d && !pwrite) ? rd_d : 32'h00000000;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_q <= `LFSH_CTRL_RST;
    end else if (wr_acc && idx == `LFSH_IDX_CTRL) begin
      ctrl_q <= pwdata[1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      irq_msk_q <= `LFSH_IRQ_RST;
    end else if (wr_acc && idx == `LFSH_IDX_IRQ_MSK) begin
      irq_msk_q <= pwdata[`LFSH_IRQ_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupts

  // Events are rising edges of the summary flags and of the halt
  assign irq_ev[`LFSH_FLG_SOME] = bus.flags[`LFSH_FLG_SOME] &&
    !flags_q[`LFSH_FLG_SOME];
  assign irq_ev[`LFSH_FLG_ALL] = bus.flags[`LFSH_FLG_ALL] &&
    !flags_q[`LFSH_FLG_ALL];
  assign irq_ev[`LFSH_FLG_RIO] = bus.flags[`LFSH_FLG_RIO] &&
    !flags_q[`LFSH_FLG_RIO];
  assign irq_ev[`LFSH_IRQ_HALT] = halt_w && !halt_q;

  // A new event beats a clear in the same cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      irq_st_q <= `LFSH_IRQ_RST;
    end else if (wr_acc && idx == `LFSH_IDX_IRQ_ST) begin
      irq_st_q <= (irq_st_q & ~pwdata[`LFSH_IRQ_W-1:0]) | irq_ev;
    end else begin
      irq_st_q <= irq_st_q | irq_ev;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(irq_st_q & irq_msk_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign rem_in = rem_in_q;
  assign rem_out = rem_out_q;
  assign link_run = link_run_q;
  assign err_flags = flags_q;
  assign irq = irq_q;

  ////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  halt_outputs_off_a: assert property (
    (prog_err || cpu_err) |=> rem_out_q == '0
  ) else $error("outputs not off after controller halt");

  halt_link_kept_a: assert property (
    (halt_w && ctrl_q[`LFSH_CTRL_LINK]) |=> link_run_q
  ) else $error("link stopped during controller halt");

  outputs_continue_a: assert property (
    !halt_w |=> rem_out_q == $past(out_img)
  ) else $error("outputs not updated while running");

  generate
    for (genvar s = 0; s < `LFSH_STN; s++) begin : g_chk
      stn_input_clear_a: assert property (
        (link_err[s] || pwr_off[s]) |=>
          rem_in_q[s*`LFSH_PTS +: `LFSH_PTS] == '0
      ) else $error("failed station inputs not cleared");

      stn_input_pass_a: assert property (
        !(link_err[s] || pwr_off[s]) |=>
          rem_in_q[s*`LFSH_PTS +: `LFSH_PTS] ==
          $past(in_raw[s*`LFSH_PTS +: `LFSH_PTS])
      ) else $error("healthy station inputs not passed");
    end
  endgenerate

  pwr_out_kept_a: assert property (
    (|pwr_off && !halt_w) |=> rem_out_q == $past(out_img)
  ) else $error("outputs disturbed by unpowered station");

  flag_some_a: assert property (
    ##1 flags_q[`LFSH_FLG_SOME] == $past(|link_err)
  ) else $error("some-station flag wrong");

  flag_all_a: assert property (
    all_fail ##1 !all_fail |=> !flags_q[`LFSH_FLG_ALL]
  ) else $error("all-station flag did not restore");

  flag_rio_a: assert property (
    ##1 flags_q[`LFSH_FLG_RIO] == $past(|rio_err)
  ) else $error("remote I/O flag wrong");

  flag_reserved_a: assert property (
    flags_q[15:3] == 13'h0000
  ) else $error("unused status bits set");

  flag_restore_a: assert property (
    $fell(|link_err) |=> !flags_q[`LFSH_FLG_SOME]
  ) else $error("flag latched after cause removed");

  irq_level_a: assert property (
    |(irq_st_q & irq_msk_q) |=> irq_q
  ) else $error("interrupt not raised");

  irq_quiet_a: assert property (
    !(|(irq_st_q & irq_msk_q)) |=> !irq_q
  ) else $error("interrupt raised with nothing pending");

  stop_outputs_off_a: assert property (
    ctrl_q[`LFSH_CTRL_STOP] |=> rem_out_q == '0
  ) else $error("outputs not off after software stop");

  flag_all_set_a: assert property (
    all_fail |=> flags_q[`LFSH_FLG_ALL]
  ) else $error("all-station flag not set");

  halt_event_a: assert property (
    $rose(halt_w) |=> irq_st_q[`LFSH_IRQ_HALT]
  ) else $error("halt event not recorded");

  // An event landing together with a clear must survive it
  irq_set_wins_a: assert property (
    (irq_ev != '0) |=> (irq_st_q & $past(irq_ev)) == $past(irq_ev)
  ) else $error("status event lost");

  irq_w1c_clear_a: assert property (
    (wr_acc && idx == `LFSH_IDX_IRQ_ST && irq_ev == '0) |=>
      (irq_st_q & $past(pwdata[`LFSH_IRQ_W-1:0])) == '0
  ) else $error("status bits not cleared by write");

  // Bus checks assume a master that keeps to the APB handshake
  ready_after_setup_a: assert property (
    (psel && !penable) |=> pready_q
  ) else $error("no ready after setup");

  ready_pulse_a: assert property (
    pready_q |=> !pready_q
  ) else $error("ready held past access phase");

  err_data_zero_a: assert property (
    pslverr_q |-> prdata_q == 32'h00000000
  ) else $error("read data not zero on error");

  halt_seen_c: cover property (
    !halt_w ##1 prog_err ##1 rem_out_q == '0
  );
  stn_drop_c: cover property (
    $rose(link_err[0]) ##1 flags_q[`LFSH_FLG_SOME]
  );
  irq_clear_c: cover property (
    irq_q ##[1:20] !irq_q
  );
  all_fail_c: cover property (
    $rose(flags_q[`LFSH_FLG_ALL])
  );
  stop_seen_c: cover property (
    $rose(ctrl_q[`LFSH_CTRL_STOP]) ##1 rem_out_q == '0
  );
endmodule

// [sim/lfsh_rem_model.sv]
// Behavioural model of the remote stations on the link
`timescale 1ns/100ps
`include "lfsh_map.svh"
module lfsh_rem_model (
  // Clock
  input wire logic clk,
  // Bench control
  input wire lfsh_pkg::lfsh_img_t sense,
  input wire lfsh_pkg::lfsh_stn_t fail,
  input wire lfsh_pkg::lfsh_stn_t unpow,
  // Link
  input wire lfsh_pkg::lfsh_img_t rem_out,
  output lfsh_pkg::lfsh_img_t in_raw,
  output lfsh_pkg::lfsh_stn_t link_err,
  output lfsh_pkg::lfsh_stn_t pwr_off,
  output logic all_fail,
  output lfsh_pkg::lfsh_img_t pins
);
  import lfsh_pkg::*;
  ////////////////////////////////////////////////////////////////////////
  // A silent station leaves junk on the wire, so gating is really seen
  always @(posedge clk) begin
    for (int s = 0; s < `LFSH_STN; s++) begin
      in_raw[4*s+:4] <= (fail[s] | unpow[s]) ? ~sense[4*s+:4] :
        sense[4*s+:4];
      pins[4*s+:4] <= unpow[s] ? 4'h0 : rem_out[4*s+:4];
    end
  end
  assign link_err = fail;
  assign pwr_off = unpow;
  assign all_fail = &fail;
endmodule

// [sim/tb_lfsh_top.sv]
// Self-checking bench of the fault handler top
`timescale 1ns/100ps
module tb_lfsh_top;
  import lfsh_pkg::*;
  localparam lfsh_img_t PAT = {32{8'hA5}};
  localparam lfsh_img_t OPAT = {32{8'h3C}};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, er, all_fail, link_run, irq;
  logic prog_err = 1'b0, cpu_err = 1'b0;
  lfsh_img_t out_img = '0, sense = '0, rem_in, rem_out, in_raw, pins;
  lfsh_stn_t fail = '0, unpow = '0, rio_err = '0, link_err, pwr_off;
  lfsh_word_t err_flags;
  int errors = 0, total_checks = 0;
  always #25 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////
  lfsh_top lfsh_top_i (.clk(clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .prog_err(prog_err), .cpu_err(cpu_err), .out_img(out_img),
    .rem_in(rem_in), .in_raw(in_raw), .link_err(link_err),
    .pwr_off(pwr_off), .rio_err(rio_err), .all_fail(all_fail),
    .rem_out(rem_out), .link_run(link_run), .err_flags(err_flags),
    .irq(irq));
  lfsh_rem_model lfsh_rem_model_i (.clk(clk), .sense(sense), .fail(fail),
    .unpow(unpow), .rem_out(rem_out), .in_raw(in_raw),
    .link_err(link_err), .pwr_off(pwr_off), .all_fail(all_fail),
    .pins(pins));
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(string n, logic [255:0] g, logic [255:0] x);
    total_checks++;
    if (g !== x) begin
      errors++;
      $display("[ERR] %s exp %h got %h", n, x, g);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Slave latency is not assumed; only the watchdog ends a stuck wait
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d,
    output logic [31:0] r, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic step;
    repeat (3) @(posedge clk);
    #1;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    #200000;
    errors++;
    print_verdict;
  end
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, 12'h074, 32'h0, rd, er); chk("flags rst", rd, 32'h0);
    apb(1'b0, 12'h0C0, 32'h0, rd, er); chk("ctrl rst", rd, 32'h2);
    apb(1'b0, 12'h3F0, 32'h0, rd, er);
    chk("unmapped", {er, rd}, 33'h1_0000_0000);
    apb(1'b0, 12'h075, 32'h0, rd, er);
    chk("misalign", {er, rd}, 33'h1_0000_0000);
    apb(1'b1, 12'h074, 32'hFFFF, rd, er);
    apb(1'b0, 12'h074, 32'h0, rd, er); chk("flags ro", rd, 32'h0);
    apb(1'b1, 12'h0C8, 32'h1, rd, er);
    sense <= PAT;
    out_img <= OPAT;
    step;
    chk("in normal", rem_in, PAT);
    chk("pins normal", pins, OPAT);
    fail <= 64'h8;
    step;
    chk("in fail", rem_in, PAT & ~(256'hF << 12));
    chk("out fail", rem_out, OPAT);
    chk("flag some", err_flags, 16'h1);
    chk("irq set", irq, 1'b1);
    apb(1'b0, 12'h010, 32'h0, rd, er); chk("lerr word", rd, 32'h8);
    apb(1'b0, 12'h074, 32'h0, rd, er); chk("flags reg", rd, 32'h1);
    fail <= '0;
    @(posedge clk);
    #1;
    chk("some back", err_flags, 16'h0);
    apb(1'b0, 12'h0C4, 32'h0, rd, er); chk("irq status", rd, 32'h1);
    apb(1'b1, 12'h0C4, 32'h1, rd, er);
    step;
    chk("irq clear", irq, 1'b0);
    rio_err <= 64'h1000_0000_0000_0000;
    step;
    chk("flag rio", err_flags, 16'h4);
    chk("irq masked", irq, 1'b0);
    apb(1'b0, 12'h02C, 32'h0, rd, er); chk("rio word", rd, 32'h1000);
    rio_err <= '0;
    @(posedge clk);
    #1;
    chk("rio back", err_flags, 16'h0);
    unpow <= 64'h20;
    step;
    chk("in unpow", rem_in, PAT & ~(256'hF << 20));
    chk("out unpow", rem_out, OPAT);
    chk("pins unpow", pins, OPAT & ~(256'hF << 20));
    chk("run unpow", link_run, 1'b1);
    unpow <= '0;
    for (int k = 0; k < 3; k++) begin
      prog_err <= (k == 0);
      cpu_err <= (k == 1);
      if (k == 2) apb(1'b1, 12'h0C0, 32'h3, rd, er);
      step;
      chk("out halt", rem_out, '0);
      chk("in halt", rem_in, PAT);
      chk("run halt", link_run, 1'b1);
    end
    apb(1'b1, 12'h0C0, 32'h2, rd, er);
    step;
    chk("out resume", rem_out, OPAT);
    fail <= '1;
    step;
    chk("flags all", err_flags, 16'h3);
    chk("in all", rem_in, '0);
    fail <= '0;
    @(posedge clk);
    #1;
    chk("all back", err_flags, 16'h0);
    apb(1'b0, 12'h0C4, 32'h0, rd, er);
    chk("irq events", rd, 32'hF);
    apb(1'b1, 12'h0C0, 32'h0, rd, er);
    step;
    chk("run off", link_run, 1'b0);
    chk("out run off", rem_out, OPAT);
    print_verdict;
  end
endmodule
